/* rtl/sea_defs.svh */
// Constants and operating summary for the serial EEPROM access slave
// Summary of operation
// R1: Master uses chip-select bits as A15-A17.
// R2: Sequential read stays inside this device's array.
// R3: Reduced-pin variant: lower select bits sent zero.
// R4: Byte write: control, address high, low, data.
// R5: Stop starts write cycle; no acknowledge meanwhile.
// R6: Protected write acknowledged, nothing written, ready.
// R7: After byte write pointer is written plus one.
// R8: Page write buffers 64 bytes, commits after Stop.
// R9: Page bytes increment only six low pointer bits.
// R10: Over 64 bytes roll over, overwrite buffer.
// R11: Page crossing wraps to start of page.
// R12: Master software avoids page-crossing writes; the bench writes across a page end on purpose.
// R13: Protect input sampled at Stop, whole array.
// R14: Master may poll right after Stop.
// R15: Master repeats Start and control until acknowledged.
// R16: After write cycle, control byte is acknowledged.
// R17: Read/write bit one selects three read kinds.
// R18: Current read sends byte at pointer, acknowledged control.
// R19: Master nack then Stop ends the read.
// R20: Repeated Start keeps loaded pointer for random read.
// R21: After random read pointer is read plus one.
// R22: Acknowledged reads continue; pointer wraps 7FFF to 0000.
// R23: Acknowledge control only on code and select match.
// R24: Fifteen address bits, high byte first.
// R25: Master nack makes device release data line.
// R26: Write cycle timed by configurable timer.
`ifndef SEA_DEFS_SVH
`define SEA_DEFS_SVH

`define SEA_ADDR_W     15
`define SEA_PAGE_W     6
`define SEA_CODE_MSB   7
`define SEA_CODE_LSB   4
`define SEA_CS_MSB     3
`define SEA_CS_LSB     1
`define SEA_RW_BIT     0
`define SEA_BITS_BYTE  4'h8
// Plain default; set to the array's real write time in cycles
`define SEA_TWC_CYC    100000

`endif

/* rtl/sea_pkg.sv */
// Types shared by the serial EEPROM access slave
package sea_pkg;

    typedef enum logic [2:0] {
        st_idle    = 3'b000,
        st_ctrl    = 3'b001,
        st_addr_hi = 3'b010,
        st_addr_lo = 3'b011,
        st_wdata   = 3'b100,
        st_rdata   = 3'b101
    } sea_state_e;

endpackage : sea_pkg

/* rtl/sea_bus_sync.sv */
// Pin synchroniser and bus condition detector
`timescale 1ns/1ps
module sea_bus_sync (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Raw pins
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic       wp_i,
    input  wire logic [2:0] cs_i,
    // Synchronised levels
    output logic            sda_s,
    output logic            wp_s,
    output logic [2:0]      cs_s,
    // Bus events
    output logic            scl_rise,
    output logic            scl_fall,
    output logic            start_p,
    output logic            stop_p
);

    logic [5:0] meta_ff;
    logic [5:0] sync_ff;
    logic       scl_prev_ff;
    logic       sda_prev_ff;
    logic       scl_s;

    // -----------------------------------------------------------------
    // Two-stage synchronisers
    // -----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_ff     <= 6'h3F;
            sync_ff     <= 6'h3F;
            scl_prev_ff <= 1'b1;
            sda_prev_ff <= 1'b1;
        end else begin
            meta_ff     <= {cs_i, wp_i, sda_i, scl_i};
            sync_ff     <= meta_ff;
            scl_prev_ff <= sync_ff[0];
            sda_prev_ff <= sync_ff[1];
        end
    end

    assign scl_s = sync_ff[0];
    assign sda_s = sync_ff[1];
    assign wp_s  = sync_ff[2];
    assign cs_s  = sync_ff[5:3];

    // -----------------------------------------------------------------
    // Edges and Start/Stop
    // -----------------------------------------------------------------
    assign scl_rise = scl_s & ~scl_prev_ff;
    assign scl_fall = ~scl_s & scl_prev_ff;
    // Data moving while clock stays high marks a bus condition
    assign start_p  = scl_s & scl_prev_ff & sda_prev_ff & ~sda_s;
    assign stop_p   = scl_s & scl_prev_ff & ~sda_prev_ff & sda_s;

endmodule : sea_bus_sync

/* rtl/sea_wr_timer.sv */
// Self-timed write cycle timer
`timescale 1ns/1ps
module sea_wr_timer #(
    parameter int CYCLES = 100000
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Control
    input  wire logic start,
    // Status
    output logic      busy,
    output logic      done
);

    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_ff;
    logic          busy_ff;
    logic          done_ff;
    logic          expire;

    assign expire = busy_ff & (cnt_ff == LAST);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_ff  <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= expire;                           // see R26
            if (start & ~busy_ff) begin
                busy_ff <= 1'b1;
                cnt_ff  <= '0;
            end else if (expire) begin
                busy_ff <= 1'b0;
            end else if (busy_ff) begin
                cnt_ff <= cnt_ff + 1'b1;
            end
        end
    end

    assign busy = busy_ff;
    assign done = done_ff;

    a_timer_length: assert property (@(posedge clk) disable iff (!rst_b) // see R26
        $fell(busy_ff) |-> $past(cnt_ff) == LAST && done_ff)
        else $error("write cycle ended at wrong count");

endmodule : sea_wr_timer

/* rtl/sea_slave.sv */
// Two-wire serial EEPROM slave: addressing, page buffer, reads
`timescale 1ns/1ps
`include "sea_defs.svh"
module sea_slave #(
    parameter int          ADDR_W   = `SEA_ADDR_W,
    parameter int          PAGE_W   = `SEA_PAGE_W,
    // Device type code; value is arbitrary
    parameter logic [3:0]  DEV_CODE = 4'hB,
    parameter int          TWC_CYC  = `SEA_TWC_CYC
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Serial bus
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe,
    // Straps
    input  wire logic chip_select_bit0,
    input  wire logic chip_select_bit1,
    input  wire logic chip_select_bit2,
    input  wire logic wp_i,
    // Status
    output logic      wr_busy
);

    localparam int NPAGE = 1 << PAGE_W;
    localparam int NMEM  = 1 << ADDR_W;

    // -----------------------------------------------------------------
    // Synchronisers and timer
    // -----------------------------------------------------------------
    logic       sda_s;
    logic       wp_s;
    logic [2:0] cs_s;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_p;
    logic       stop_p;
    logic       cyc_start;
    logic       busy;
    logic       cyc_done;

    sea_bus_sync u_sync (
        .clk      (clk),
        .rst_b    (rst_b),
        .scl_i    (scl_i),
        .sda_i    (sda_i),
        .wp_i     (wp_i),
        .cs_i     ({chip_select_bit2, chip_select_bit1, chip_select_bit0}),
        .sda_s    (sda_s),
        .wp_s     (wp_s),
        .cs_s     (cs_s),
        .scl_rise (scl_rise),
        .scl_fall (scl_fall),
        .start_p  (start_p),
        .stop_p   (stop_p)
    );

    sea_wr_timer #(
        .CYCLES (TWC_CYC)
    ) u_tmr (
        .clk   (clk),
        .rst_b (rst_b),
        .start (cyc_start),
        .busy  (busy),
        .done  (cyc_done)
    );

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    sea_pkg::sea_state_e st_ff;
    sea_pkg::sea_state_e nxt_st;
    logic [3:0]          bit_cnt_ff;
    logic                in_ack_ff;
    logic [7:0]          shreg_ff;
    logic [7:0]          txsh_ff;
    logic [ADDR_W-1:0]   ptr_ff;
    logic [ADDR_W-1:0]   nxt_ptr;
    logic                got_data_ff;
    logic                tx_go_ff;
    logic                sda_oe_ff;
    logic                nxt_oe;
    logic [7:0]          buf_ff [NPAGE];
    logic [NPAGE-1:0]    vld_ff;
    logic [7:0]          mem_ff [NMEM];

    // Only the low page bits move, so bytes stay inside one page
    function automatic logic [ADDR_W-1:0] page_inc(input logic [ADDR_W-1:0] a);
        page_inc = {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + 1'b1};
    endfunction : page_inc

    // -----------------------------------------------------------------
    // Decode
    // -----------------------------------------------------------------
    wire       active    = (st_ff != sea_pkg::st_idle);
    wire       byte_done = active & scl_fall & ~in_ack_ff & (bit_cnt_ff == `SEA_BITS_BYTE);
    wire       bit_rise  = active & scl_rise & ~in_ack_ff & (bit_cnt_ff != `SEA_BITS_BYTE);
    wire       ack_rise  = scl_rise & in_ack_ff;
    wire       ack_end   = scl_fall & in_ack_ff;
    wire       is_ctrl   = (st_ff == sea_pkg::st_ctrl);
    wire       is_hi     = (st_ff == sea_pkg::st_addr_hi);
    wire       is_lo     = (st_ff == sea_pkg::st_addr_lo);
    wire       is_wdata  = (st_ff == sea_pkg::st_wdata);
    wire       is_rdata  = (st_ff == sea_pkg::st_rdata);
    wire       code_ok   = (shreg_ff[`SEA_CODE_MSB:`SEA_CODE_LSB] == DEV_CODE);
    wire       cs_ok     = (shreg_ff[`SEA_CS_MSB:`SEA_CS_LSB] == cs_s);
    wire       rd_req    = shreg_ff[`SEA_RW_BIT];
    // Silent while the write cycle runs
    wire       ctrl_ok   = code_ok & cs_ok & ~busy;                // see R5 R16 R23
    wire       accept    = byte_done & is_ctrl & ctrl_ok;
    wire       rx_ack    = accept | (byte_done & (is_hi | is_lo | is_wdata));
    wire       buf_wr    = byte_done & is_wdata;
    wire       ld_byte   = ack_end & is_rdata & tx_go_ff;
    wire       tx_bit    = scl_fall & ~in_ack_ff & is_rdata & (bit_cnt_ff != 4'h0)
                           & (bit_cnt_ff != `SEA_BITS_BYTE);
    wire [7:0] rd_byte   = mem_ff[ptr_ff];
    // Protect level taken at the Stop decides the cycle
    assign cyc_start = stop_p & is_wdata & got_data_ff & ~wp_s;    // see R5 R6 R13

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        if (start_p) begin
            nxt_st = sea_pkg::st_ctrl;
        end else if (stop_p) begin
            nxt_st = sea_pkg::st_idle;
        end else if (byte_done) begin
            case (st_ff)
                sea_pkg::st_ctrl: begin
                    if (!ctrl_ok) begin
                        nxt_st = sea_pkg::st_idle;                  // see R23
                    end else if (rd_req) begin
                        nxt_st = sea_pkg::st_rdata;                 // see R17
                    end else begin
                        nxt_st = sea_pkg::st_addr_hi;               // see R4
                    end
                end
                sea_pkg::st_addr_hi: nxt_st = sea_pkg::st_addr_lo;  // see R24
                sea_pkg::st_addr_lo: nxt_st = sea_pkg::st_wdata;
                default:             nxt_st = st_ff;
            endcase
        end else if (ack_end & is_rdata & ~tx_go_ff) begin
            nxt_st = sea_pkg::st_idle;                              // see R19 R25
        end
    end

    // -----------------------------------------------------------------
    // Pointer
    // -----------------------------------------------------------------
    always_comb begin
        nxt_ptr = ptr_ff;
        if (byte_done & is_hi) begin
            // Top bit of the high byte is ignored
            nxt_ptr = {shreg_ff[ADDR_W-9:0], ptr_ff[7:0]};          // see R24
        end else if (byte_done & is_lo) begin
            nxt_ptr = {ptr_ff[ADDR_W-1:8], shreg_ff};
        end else if (buf_wr) begin
            nxt_ptr = page_inc(ptr_ff);                             // see R7 R9 R10 R11
        end else if (ld_byte) begin
            // Wraps inside this array only
            nxt_ptr = ptr_ff + 1'b1;                                // see R2 R18 R21 R22
        end
    end

    // -----------------------------------------------------------------
    // Data line drive (open drain: enable pulls low)
    // -----------------------------------------------------------------
    always_comb begin
        nxt_oe = sda_oe_ff;
        if (start_p | stop_p) begin
            nxt_oe = 1'b0;
        end else if (byte_done) begin
            nxt_oe = rx_ack;                                        // see R4 R6 R18
        end else if (ack_end) begin
            nxt_oe = ld_byte & ~rd_byte[7];                         // see R25
        end else if (tx_bit) begin
            nxt_oe = ~txsh_ff[7];
        end
    end

    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_ff      <= sea_pkg::st_idle;
            ptr_ff     <= '0;
            sda_oe_ff  <= 1'b0;
            in_ack_ff  <= 1'b0;
            bit_cnt_ff <= 4'h0;
        end else begin
            st_ff     <= nxt_st;
            ptr_ff    <= nxt_ptr;
            sda_oe_ff <= nxt_oe;
            if (start_p | stop_p | ack_end) begin
                in_ack_ff <= 1'b0;
            end else if (byte_done) begin
                in_ack_ff <= 1'b1;
            end
            if (start_p | byte_done) begin
                bit_cnt_ff <= 4'h0;
            end else if (bit_rise) begin
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            shreg_ff    <= 8'h00;
            txsh_ff     <= 8'h00;
            got_data_ff <= 1'b0;
            tx_go_ff    <= 1'b0;
        end else begin
            if (bit_rise) begin
                shreg_ff <= {shreg_ff[6:0], sda_s};
            end
            if (ld_byte) begin
                txsh_ff <= {rd_byte[6:0], 1'b0};
            end else if (tx_bit) begin
                txsh_ff <= {txsh_ff[6:0], 1'b0};
            end
            // Repeated Start drops unwritten data but keeps the pointer
            if (start_p | stop_p) begin
                got_data_ff <= 1'b0;                                // see R20
            end else if (buf_wr) begin
                got_data_ff <= 1'b1;
            end
            if (accept) begin
                tx_go_ff <= 1'b1;
            end else if (ack_rise & is_rdata) begin
                tx_go_ff <= ~sda_s;                                 // see R22
            end
        end
    end

    // -----------------------------------------------------------------
    // Page buffer and array
    // -----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            vld_ff <= '0;
        end else if ((byte_done & is_lo) | cyc_done) begin
            vld_ff <= '0;
        end else if (buf_wr) begin
            vld_ff[ptr_ff[PAGE_W-1:0]] <= 1'b1;                     // see R8
        end
    end

    always_ff @(posedge clk) begin
        if (buf_wr) begin
            buf_ff[ptr_ff[PAGE_W-1:0]] <= shreg_ff;                 // see R8 R10
        end
    end

    // Array changes only when the timed cycle ends
    always_ff @(posedge clk) begin
        for (int i = 0; i < NPAGE; i++) begin
            if (cyc_done & vld_ff[i]) begin
                mem_ff[{ptr_ff[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= buf_ff[i]; // see R26
            end
        end
    end

    assign sda_o   = 1'b0;
    assign sda_oe  = sda_oe_ff;
    assign wr_busy = busy;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_busy_no_ack: assert property ( // see R5
        byte_done & is_ctrl & busy |=> !sda_oe_ff && st_ff == sea_pkg::st_idle)
        else $error("control byte acknowledged during write cycle");

    a_protect_no_cycle: assert property ( // see R6
        stop_p & is_wdata & got_data_ff & wp_s & !busy |=> (!busy)[*3])
        else $error("protected write started a cycle");

    a_stop_starts_cycle: assert property ( // see R13
        stop_p & is_wdata & got_data_ff & !wp_s & !busy |=> ##1 busy)
        else $error("write cycle not started at stop");

    a_page_wrap: assert property ( // see R9
        buf_wr |=> ptr_ff[ADDR_W-1:PAGE_W] == $past(ptr_ff[ADDR_W-1:PAGE_W])
                && ptr_ff[PAGE_W-1:0] == PAGE_W'($past(ptr_ff[PAGE_W-1:0]) + 1))
        else $error("page pointer left its page");

    a_read_advance: assert property ( // see R22
        ld_byte |=> ptr_ff == ADDR_W'($past(ptr_ff) + 1) && txsh_ff[7] == $past(rd_byte[6]))
        else $error("read pointer did not advance by one");

    a_select_match: assert property ( // see R23
        byte_done & is_ctrl |=> in_ack_ff && sda_oe_ff ==
            ($past(shreg_ff[`SEA_CODE_MSB:`SEA_CODE_LSB]) == DEV_CODE
             && $past(shreg_ff[`SEA_CS_MSB:`SEA_CS_LSB]) == $past(cs_s) && !$past(busy)))
        else $error("control byte answer disagrees with select match");

    a_nack_release: assert property ( // see R25
        ack_end & is_rdata & !tx_go_ff |=> !sda_oe_ff && st_ff == sea_pkg::st_idle)
        else $error("data line held after master nack");

    a_addr_high: assert property ( // see R24
        byte_done & is_hi |=> ptr_ff[ADDR_W-1:8] == $past(shreg_ff[ADDR_W-9:0]))
        else $error("high address byte loaded wrongly");

    c_byte_write: cover property (stop_p & is_wdata & got_data_ff & !wp_s);
    c_seq_read:   cover property (ld_byte ##[1:400] ld_byte);
    c_poll_nack:  cover property (byte_done & is_ctrl & busy);

endmodule : sea_slave

/* testbench/sea_master.sv */
// Two-wire bus master model that drives clock and data towards the slave
`timescale 1ns/1ps
module sea_master (
    // Clock
    input  wire logic clk,
    // Bus
    output logic      scl_o,
    output logic      sda_low,
    input  wire logic sda
);
    // Idle bus: clock parked high, data released to the pull-up
    initial begin
        scl_o   = 1'b1;
        sda_low = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_clk

    // Data moves mid-low only, so no false Start or Stop appears
    task automatic bit_io(input logic pull, output logic seen);
        scl_o <= 1'b0;
        wait_clk(2);
        sda_low <= pull;
        wait_clk(2);
        scl_o <= 1'b1;
        wait_clk(4);
        seen = sda;
    endtask : bit_io

    task automatic start_cond();
        logic s;
        bit_io(1'b0, s);
        sda_low <= 1'b1;
        wait_clk(4);
    endtask : start_cond

    task automatic stop_cond();
        logic s;
        bit_io(1'b1, s);
        sda_low <= 1'b0;
        wait_clk(4);
    endtask : stop_cond

    // Most significant bit first, ninth clock left free for the answer
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(~b[i], s);
        end
        bit_io(1'b0, s);
        ack = ~s;
    endtask : send_byte

    task automatic recv_byte(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b0, s);
            d[i] = s;
        end
        bit_io(more, s);
    endtask : recv_byte
endmodule : sea_master

/* testbench/tb.sv */
// Self-checking bench for the serial EEPROM access slave
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb;
    localparam logic [3:0] CODE = 4'hB;
    localparam logic [2:0] SEL  = 3'b101;
    logic       clk    = 1'b0;
    logic       rst_b  = 1'b0;
    logic       wp     = 1'b0;
    logic [2:0] cs     = SEL;
    logic       scl;
    logic       m_low;
    logic       sda_o;
    logic       sda_oe;
    logic       wr_busy;
    int         errors = 0;
    int         checks = 0;
    // Open drain with pull-up: low while either party pulls
    wire        sda    = ~(sda_oe | m_low);

    always #5 clk = ~clk;

    sea_slave #(.TWC_CYC(200)) sea_slave_i (
        .clk              (clk),
        .rst_b            (rst_b),
        .scl_i            (scl),
        .sda_i            (sda),
        .sda_o            (sda_o),
        .sda_oe           (sda_oe),
        .chip_select_bit0 (cs[0]),
        .chip_select_bit1 (cs[1]),
        .chip_select_bit2 (cs[2]),
        .wp_i             (wp),
        .wr_busy          (wr_busy)
    );

    sea_master sea_master_i (
        .clk     (clk),
        .scl_o   (scl),
        .sda_low (m_low),
        .sda     (sda)
    );

    // ----------------------------------------
    // Bus sequences
    // ----------------------------------------
    function automatic logic [7:0] ctrl(input logic [2:0] sel, input logic rd);
        return {CODE, sel, rd};
    endfunction : ctrl

    task automatic put(input logic [7:0] b, input logic exp_ack);
        logic a;
        sea_master_i.send_byte(b, a);
        `CHK("ack", exp_ack, a)
    endtask : put

    // Top address bit sent as one: it must be ignored
    task automatic set_ptr(input logic [14:0] a);
        sea_master_i.start_cond();
        put(ctrl(SEL, 1'b0), 1'b1);
        put({1'b1, a[14:8]}, 1'b1);
        put(a[7:0], 1'b1);
    endtask : set_ptr

    task automatic wr(input logic [14:0] a, input logic [7:0] q[$], input logic busy_exp);
        int   n;
        logic ack;
        set_ptr(a);
        foreach (q[i]) put(q[i], 1'b1);
        sea_master_i.stop_cond();
        wp <= 1'b0;
        sea_master_i.wait_clk(4);
        `CHK("busy", busy_exp, wr_busy)
        n   = 0;
        ack = 1'b0;
        while (!ack && n < 20) begin
            sea_master_i.start_cond();
            sea_master_i.send_byte(ctrl(SEL, 1'b0), ack);
            n++;
        end
        `CHK("poll ack", 1'b1, ack)
        `CHK("polled", busy_exp, n > 1)
        sea_master_i.stop_cond();
    endtask : wr

    task automatic rd(input logic set, input logic [14:0] a, input logic [7:0] q[$]);
        logic [7:0] d;
        logic       s;
        if (set) set_ptr(a);
        sea_master_i.start_cond();
        put(ctrl(SEL, 1'b1), 1'b1);
        foreach (q[i]) begin
            sea_master_i.recv_byte(i < q.size() - 1, d);
            `CHK("data", q[i], d)
        end
        `CHK("released", 1'b0, sda_oe)
        // Spare clock with data released: an idle device leaves the line high
        sea_master_i.bit_io(1'b0, s);
        `CHK("line high", 1'b1, s)
        sea_master_i.stop_cond();
    endtask : rd

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        logic [7:0] big[$];
        for (int i = 0; i < 65; i++) big.push_back(8'(i + 1));
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("idle", 3'b000, {sda_oe, wr_busy, sda_o})
        wr(15'h0100, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55}, 1'b1);
        rd(1'b1, 15'h0100, '{8'h11});
        rd(1'b0, 15'h0000, '{8'h22});
        rd(1'b0, 15'h0000, '{8'h33});
        $display("test reads done");
        wr(15'h0102, '{8'hA5}, 1'b1);
        rd(1'b0, 15'h0000, '{8'h44});
        $display("test byte write done");
        // Deliberately crosses a page end
        wr(15'h017E, '{8'h66, 8'h77, 8'h88}, 1'b1);
        rd(1'b1, 15'h017E, '{8'h66, 8'h77});
        rd(1'b1, 15'h0140, '{8'h88});
        wr(15'h0200, big, 1'b1);
        rd(1'b1, 15'h0200, '{8'h41, 8'h02});
        $display("test page done");
        wp <= 1'b1;
        wr(15'h0100, '{8'hFF}, 1'b0);
        rd(1'b1, 15'h0100, '{8'h11});
        $display("test protect done");
        sea_master_i.start_cond();
        put(ctrl(3'b100, 1'b0), 1'b0);
        sea_master_i.start_cond();
        put({4'h5, SEL, 1'b0}, 1'b0);
        cs <= 3'b011;
        sea_master_i.start_cond();
        put(ctrl(3'b011, 1'b0), 1'b1);
        sea_master_i.stop_cond();
        cs <= 3'b100;
        sea_master_i.start_cond();
        put(ctrl(3'b100, 1'b0), 1'b1);
        sea_master_i.stop_cond();
        cs <= SEL;
        $display("test select done");
        wr(15'h7FFF, '{8'h9C}, 1'b1);
        wr(15'h0000, '{8'h3C}, 1'b1);
        rd(1'b1, 15'h7FFF, '{8'h9C, 8'h3C});
        $display("test wrap done");
        give_verdict();
    end

    // Whole run is near 125 us; four times that means a hang
    initial begin
        #500000;
        errors++;
        give_verdict();
    end
endmodule : tb
